// file: lpg_cfg_if.sv
// Settings and status carried between register file and pulse timing
`default_nettype none
interface lpg_cfg_if;
   import lpg_pkg::*;
   lpg_cfg_type cfg;
   logic [21:0] status;
   modport regs (output cfg, input status);
   modport timing (input cfg, output status);
endinterface
`default_nettype wire

// file: lpg_panel_model.sv
// Panel side: measures the high time of the first sampling clock
`default_nettype none
module lpg_panel_model (
   input wire logic clk_in,
   input wire logic sample_in,
   output logic [7:0] high_len_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] run_ff;
   logic last_ff;
   // A run cut short by enabling is kept too, so readers skip the first
   always_ff @(posedge clk_in)
   begin
      last_ff <= sample_in;
      run_ff <= sample_in ? run_ff + 8'h01 : 8'h00;
      if (last_ff && !sample_in)
         high_len_out <= run_ff;
   end
endmodule
`default_nettype wire

// file: lpg_pkg.sv
// Constants and types shared by the LCD panel drive pulse generator
`default_nettype none
package lpg_pkg;
   // Register indices; byte address is four times the index
   localparam logic [13:0] IDX_LINK = 14'h1000;
   localparam logic [13:0] IDX_POL = 14'h1001;
   localparam logic [13:0] IDX_FIX = 14'h1002;
   localparam logic [13:0] IDX_ACPOS_LO = 14'h100e;
   localparam logic [13:0] IDX_ACPOS_HI = 14'h100f;
   localparam logic [13:0] IDX_SHP = 14'h1015;
   localparam logic [13:0] IDX_PERIOD = 14'h101a;
   localparam logic [13:0] IDX_DUAL = 14'h101b;
   localparam logic [13:0] IDX_VPOS_HI = 14'h1021;
   localparam logic [13:0] IDX_VCPOS_LO = 14'h1024;
   localparam logic [13:0] IDX_VSPOS_LO = 14'h1025;
   localparam logic [13:0] IDX_OE_A = 14'h102c;
   localparam logic [13:0] IDX_OE_B = 14'h102d;
   localparam logic [13:0] IDX_LINE = 14'h1030;
   localparam logic [13:0] IDX_FRAME = 14'h1031;
   localparam logic [13:0] IDX_STATUS = 14'h1032;
   // Bit positions inside the byte registers
   localparam int B_SHARED = 0;
   localparam int B_HDIR = 1;
   localparam int B_VDIR = 2;
   localparam int B_SPOL = 0;
   localparam int B_DPOL = 1;
   localparam int B_VSPOL = 2;
   localparam int B_VCPOL = 3;
   localparam int B_MODE = 4;
   localparam int B_SFIX = 0;
   localparam int B_DINV = 1;
   localparam int B_DFIX = 2;
   localparam int B_VSFIX = 3;
   localparam int B_VCFIX = 4;
   localparam int B_VS_HI = 0;
   localparam int B_VC_HI = 4;
   localparam int B_AC_OE = 0;
   localparam int B_ACN_OE = 1;
   localparam int B_S_OE = 0;
   localparam int B_D_OE = 1;
   localparam int B_V_OE = 2;
   // Gate enable pulse length in dots after each shift clock edge
   localparam logic [5:0] ENB_DOTS = 6'h08;
   localparam logic [10:0] LINE_MIN = 11'h040;
   typedef struct packed {
      logic shared_transition_bit;
      logic horizontal_direction;
      logic vertical_direction;
      logic sampling_pol_bit;
      logic dual_pol_bit;
      logic vstart_pol_bit;
      logic vclock_pol_bit;
      logic [1:0] ac_period_mode;
      logic sampling_pol_fix;
      logic dual_phase_invert;
      logic dual_phase_fix;
      logic vstart_pol_fix;
      logic vclock_pol_fix;
      logic [9:0] ac_invert_position;
      logic [5:0] sample_position_field;
      logic [5:0] sampling_period_field;
      logic [3:0] dual_phase_field;
      logic [3:0] dual_width_field;
      logic [9:0] vstart_position_field;
      logic [9:0] vclock_position_field;
      logic ac_out_enable;
      logic ac_comp_out_enable;
      logic sampling_out_enable;
      logic dual_out_enable;
      logic vertical_out_enable;
      logic [10:0] line_dots;
      logic [10:0] frame_lines;
   } lpg_cfg_type;
   localparam lpg_cfg_type CFG_RST = '{horizontal_direction: 1'b1,
      vertical_direction: 1'b1, ac_period_mode: 2'h3, sampling_period_field: 6'h0b,
      line_dots: 11'h320, frame_lines: 11'h20d, default: '0};
endpackage
`default_nettype wire

// file: lpg_properties.sv
// Port-level checks for the drive pulse generator
`default_nettype none
module lpg_properties (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic hsel_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_out,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic sampling_clock_a_out,
   input wire logic sampling_clock_b_out,
   input wire logic vertical_start_pulse_out,
   input wire logic gate_enable_pulse_out,
   input wire logic ac_drive_pulse_out,
   input wire logic ac_drive_pulse_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rd_ph_ff;
   logic [4:0] ge_run_ff;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // Run length counts prior high cycles, so 15 marks the sixteenth
   always_ff @(posedge clk_in)
   begin
      rd_ph_ff <= hsel_in & hready_in & htrans_in[1] & ~hwrite_in;
      ge_run_ff <= gate_enable_pulse_out ? ge_run_ff + 5'h01 : 5'h00;
   end
   AST_RESP_OKAY: assert property (hresp_out == 1'b0)
      else $error("response not okay");
   AST_RESET_EXIT: assert property ($rose(rst_n_in) |-> !hreadyout_out
      && !sampling_clock_a_out && !ac_drive_pulse_out ##1 hreadyout_out)
      else $error("ready or pulse wrong around reset release");
   AST_NO_WAIT: assert property ($past(rst_n_in) |-> hreadyout_out)
      else $error("wait state inserted");
   AST_RDATA_IDLE: assert property (!rd_ph_ff |-> hrdata_out == 32'h0)
      else $error("read data outside read data phase");
   AST_SAMP_COMPL: assert property (!(sampling_clock_a_out && sampling_clock_b_out))
      else $error("both sampling clocks high");
   AST_AC_COMPL: assert property (!(ac_drive_pulse_out && ac_drive_pulse_n_out))
      else $error("ac pulse and complement both high");
   AST_GATE_LEN: assert property (gate_enable_pulse_out |-> ge_run_ff <= 5'd15)
      else $error("gate enable longer than sixteen cycles");
   AST_VSTART_HOLD: assert property ($rose(vertical_start_pulse_out)
      |-> vertical_start_pulse_out[*8])
      else $error("vertical start pulse too short");
   COV_READ: cover property (rd_ph_ff);
   COV_GATE: cover property ($rose(gate_enable_pulse_out));
   COV_AC: cover property ($changed(ac_drive_pulse_out));
endmodule
`default_nettype wire

// file: lpg_regs.sv
// AHB-Lite register file for the drive pulse generator
`default_nettype none
module lpg_regs #(
   parameter int ADDR_W = 16
)(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic hsel_in,
   input wire logic [ADDR_W-1:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic hready_in,
   input wire logic [31:0] hwdata_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   lpg_cfg_if.regs cfg_if
);
   import lpg_pkg::*;
   lpg_cfg_type cfg_ff, nxt_cfg;
   logic [13:0] idx_ff, nxt_idx;
   logic wr_ff, nxt_wr;
   logic [31:0] rdata_ff, nxt_rdata;
   logic take;

   if (ADDR_W < 16) $error("lpg_regs: ADDR_W below 16 cannot reach the map");

   function automatic logic [31:0] rd_word(input lpg_cfg_type c, input logic [13:0] i,
                                           input logic [21:0] st);
      rd_word = '0;
      case (i)
         IDX_LINK: rd_word[2:0] = {c.vertical_direction, c.horizontal_direction,
                                   c.shared_transition_bit};
         IDX_POL: rd_word[5:0] = {c.ac_period_mode, c.vclock_pol_bit, c.vstart_pol_bit,
                                  c.dual_pol_bit, c.sampling_pol_bit};
         IDX_FIX: rd_word[4:0] = {c.vclock_pol_fix, c.vstart_pol_fix, c.dual_phase_fix,
                                  c.dual_phase_invert, c.sampling_pol_fix};
         IDX_ACPOS_LO: rd_word[7:0] = c.ac_invert_position[7:0];
         IDX_ACPOS_HI: rd_word[1:0] = c.ac_invert_position[9:8];
         IDX_SHP: rd_word[5:0] = c.sample_position_field;
         IDX_PERIOD: rd_word[5:0] = c.sampling_period_field;
         IDX_DUAL: rd_word[7:0] = {c.dual_width_field, c.dual_phase_field};
         IDX_VPOS_HI: rd_word[5:0] = {c.vclock_position_field[9:8], 2'h0,
                                      c.vstart_position_field[9:8]};
         IDX_VCPOS_LO: rd_word[7:0] = c.vclock_position_field[7:0];
         IDX_VSPOS_LO: rd_word[7:0] = c.vstart_position_field[7:0];
         IDX_OE_A: rd_word[1:0] = {c.ac_comp_out_enable, c.ac_out_enable};
         IDX_OE_B: rd_word[2:0] = {c.vertical_out_enable, c.dual_out_enable,
                                   c.sampling_out_enable};
         IDX_LINE: rd_word[10:0] = c.line_dots;
         IDX_FRAME: rd_word[10:0] = c.frame_lines;
         IDX_STATUS: rd_word[21:0] = st;
         default: rd_word = '0;
      endcase
   endfunction

   always_comb
   begin
      logic [7:0] d;
      d = hwdata_in[7:0];
      take = hsel_in & hready_in & htrans_in[1];
      nxt_idx = take ? haddr_in[15:2] : idx_ff;
      nxt_wr = take & hwrite_in;
      nxt_cfg = cfg_ff;
      if (wr_ff)
      begin
         case (idx_ff)
            IDX_LINK:
            begin
               nxt_cfg.shared_transition_bit = d[B_SHARED];
               nxt_cfg.horizontal_direction = d[B_HDIR];
               nxt_cfg.vertical_direction = d[B_VDIR];
            end
            IDX_POL:
            begin
               nxt_cfg.sampling_pol_bit = d[B_SPOL];
               nxt_cfg.dual_pol_bit = d[B_DPOL];
               nxt_cfg.vstart_pol_bit = d[B_VSPOL];
               nxt_cfg.vclock_pol_bit = d[B_VCPOL];
               nxt_cfg.ac_period_mode = d[B_MODE+:2];
            end
            IDX_FIX:
            begin
               nxt_cfg.sampling_pol_fix = d[B_SFIX];
               nxt_cfg.dual_phase_invert = d[B_DINV];
               nxt_cfg.dual_phase_fix = d[B_DFIX];
               nxt_cfg.vstart_pol_fix = d[B_VSFIX];
               nxt_cfg.vclock_pol_fix = d[B_VCFIX];
            end
            IDX_ACPOS_LO: nxt_cfg.ac_invert_position[7:0] = d;
            IDX_ACPOS_HI: nxt_cfg.ac_invert_position[9:8] = d[1:0];
            IDX_SHP: nxt_cfg.sample_position_field = d[5:0];
            IDX_PERIOD: nxt_cfg.sampling_period_field = d[5:0];
            IDX_DUAL: {nxt_cfg.dual_width_field, nxt_cfg.dual_phase_field} = d;
            IDX_VPOS_HI:
            begin
               nxt_cfg.vstart_position_field[9:8] = d[B_VS_HI+:2];
               nxt_cfg.vclock_position_field[9:8] = d[B_VC_HI+:2];
            end
            IDX_VCPOS_LO: nxt_cfg.vclock_position_field[7:0] = d;
            IDX_VSPOS_LO: nxt_cfg.vstart_position_field[7:0] = d;
            IDX_OE_A:
            begin
               nxt_cfg.ac_out_enable = d[B_AC_OE];
               nxt_cfg.ac_comp_out_enable = d[B_ACN_OE];
            end
            IDX_OE_B:
            begin
               nxt_cfg.sampling_out_enable = d[B_S_OE];
               nxt_cfg.dual_out_enable = d[B_D_OE];
               nxt_cfg.vertical_out_enable = d[B_V_OE];
            end
            IDX_LINE: nxt_cfg.line_dots = hwdata_in[10:0];
            IDX_FRAME: nxt_cfg.frame_lines = hwdata_in[10:0];
            default: nxt_cfg = cfg_ff;
         endcase
      end
      // Read sees a write still in its data phase
      nxt_rdata = (take & ~hwrite_in) ? rd_word(nxt_cfg, haddr_in[15:2], cfg_if.status) : '0;
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         cfg_ff <= CFG_RST;
         idx_ff <= '0;
         wr_ff <= 1'b0;
         rdata_ff <= '0;
         hreadyout_out <= 1'b0;
      end
      else
      begin
         cfg_ff <= nxt_cfg;
         idx_ff <= nxt_idx;
         wr_ff <= nxt_wr;
         rdata_ff <= nxt_rdata;
         hreadyout_out <= 1'b1;
      end
   end

   assign hrdata_out = rdata_ff;
   assign cfg_if.cfg = cfg_ff;
endmodule
`default_nettype wire

// file: lpg_top.sv
// LCD panel drive pulse generator: horizontal and vertical panel timing
// What this block does
// - Sampling clock period is sampling period field plus one, in dots.
// - Sampling polarity follows fix bit, polarity bit and horizontal direction.
// - Sampling clock enable low holds both sampling clocks low.
// - Dual clocks sit the phase field, in half dots, after the sampling edge.
// - Dual clock width is width field plus one, in dots.
// - Dual polarity bit inverts both dual clocks.
// - Invert bit, fix bit and direction pick first or second sampling edge.
// - Dual clock enable low holds both dual clocks low.
// - Each sample position step moves the horizontal group half a dot earlier.
// - Sample position moves the whole group without changing relative phases.
// - Vertical start edge sits at twice field plus two dots from line zero.
// - Vertical clock toggles at clock position field plus one dot.
// - Vertical polarity follows fix bit, polarity bit and vertical direction.
// - Vertical enable low holds start, shift clock and gate enable low.
// - Two-bit mode picks AC inversion period: 1F/1H, 2F/1H, 1F, 2F.
// - AC pulse inverts at AC position field plus one dot.
// - Complementary AC output is the inverse of the AC pulse while both AC enables are set.
// - Separate enables gate the AC pulse and its complement.
// - Shared bit forces vertical clock inversion onto the AC inversion point.
// - Horizontal phase counting restarts where line position plus sample position field wraps to zero.
// - Direction bits use one for forward scan, zero for reverse.
`default_nettype none
module lpg_top (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic hsel_in,
   input wire logic [15:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic hready_in,
   input wire logic [31:0] hwdata_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic sampling_clock_a_out,
   output logic sampling_clock_b_out,
   output logic dual_sample_clock_a_out,
   output logic dual_sample_clock_b_out,
   output logic vertical_start_pulse_out,
   output logic vertical_shift_clock_out,
   output logic gate_enable_pulse_out,
   output logic ac_drive_pulse_out,
   output logic ac_drive_pulse_n_out
);
   import lpg_pkg::*;

   lpg_cfg_if cfg_if();
   lpg_cfg_type c;

   // Only word transfers are used, so the size is not decoded
   lpg_regs #(
      .ADDR_W(16)
   ) u_regs (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .hsel_in(hsel_in),
      .haddr_in(haddr_in),
      .htrans_in(htrans_in),
      .hwrite_in(hwrite_in),
      .hready_in(hready_in),
      .hwdata_in(hwdata_in),
      .hrdata_out(hrdata_out),
      .hreadyout_out(hreadyout_out),
      .cfg_if(cfg_if)
   );

   assign c = cfg_if.cfg;

   // Positive output when true
   function automatic logic out_pos(input logic fix, input logic pol, input logic dir);
      out_pos = fix ? pol : (pol == dir);
   endfunction

   // Modular add; operands must already be below the modulus
   function automatic logic [7:0] wrap_add(input logic [7:0] a, input logic [7:0] b,
                                           input logic [8:0] m);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= m)
      begin
         s = s - m;
      end
      wrap_add = s[7:0];
   endfunction

   // Counter value lies in the window starting at s, w half-dots long
   function automatic logic in_window(input logic [7:0] p, input logic [7:0] s,
                                      input logic [5:0] w, input logic [8:0] m);
      logic [8:0] d;
      d = (p >= s) ? {1'b0, p} - {1'b0, s} : {1'b0, p} + m - {1'b0, s};
      in_window = d < {3'h0, w};
   endfunction

   // Line position counter in half dots
   logic [11:0] hpos_ff, nxt_hpos;
   logic [10:0] vline_ff, nxt_vline;
   logic frame_ff, nxt_frame;
   logic [11:0] line_half;
   logic line_end;

   always_comb
   begin
      line_half = {c.line_dots, 1'b0};
      // A line length written below the minimum runs at the minimum
      if (c.line_dots < LINE_MIN)
      begin
         line_half = {LINE_MIN, 1'b0};
      end
      line_end = hpos_ff >= line_half - 12'h001;
      nxt_hpos = line_end ? 12'h000 : hpos_ff + 12'h001;
      nxt_vline = vline_ff;
      nxt_frame = frame_ff;
      if (line_end)
      begin
         if (vline_ff >= c.frame_lines - 11'h001)
         begin
            nxt_vline = 11'h000;
            nxt_frame = ~frame_ff;
         end
         else
         begin
            nxt_vline = vline_ff + 11'h001;
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         hpos_ff <= '0;
         vline_ff <= '0;
         frame_ff <= 1'b0;
      end
      else
      begin
         hpos_ff <= nxt_hpos;
         vline_ff <= nxt_vline;
         frame_ff <= nxt_frame;
      end
   end

   assign cfg_if.status = {vline_ff, hpos_ff[11:1]};

   // Horizontal group: sampling and dual sampling clocks
   logic [7:0] hck_ff, nxt_hck;
   logic [12:0] grp_sum;
   logic grp_zero;
   logic [7:0] per_half;
   logic [8:0] per_full;
   logic [7:0] dual_a_start, dual_b_start;
   logic [5:0] dual_len;
   logic use_second;
   logic samp_raw, dual_a_raw, dual_b_raw;

   always_comb
   begin
      per_half = {2'h0, c.sampling_period_field} + 8'h01;
      per_full = {per_half, 1'b0};
      // Adding the offset makes the group reach zero earlier in the line
      grp_sum = {1'b0, hpos_ff} + {7'h00, c.sample_position_field};
      if (grp_sum >= {1'b0, line_half})
      begin
         grp_sum = grp_sum - {1'b0, line_half};
      end
      grp_zero = grp_sum == 13'h0000;
      // One counter drives all group pulses, so offsets keep them aligned
      if (grp_zero)
      begin
         nxt_hck = 8'h00;
      end
      else if ({1'b0, hck_ff} >= per_full - 9'h001)
      begin
         nxt_hck = 8'h00;
      end
      else
      begin
         nxt_hck = hck_ff + 8'h01;
      end
      samp_raw = hck_ff < per_half;
      use_second = c.dual_phase_fix ? c.dual_phase_invert
                   : (c.dual_phase_invert ^ ~c.horizontal_direction);
      dual_a_start = wrap_add(use_second ? per_half : 8'h00,
                              {4'h0, c.dual_phase_field}, per_full);
      dual_b_start = wrap_add(dual_a_start, per_half, per_full);
      dual_len = {5'({1'b0, c.dual_width_field} + 5'h01), 1'b0};
      dual_a_raw = in_window(hck_ff, dual_a_start, dual_len, per_full);
      dual_b_raw = in_window(hck_ff, dual_b_start, dual_len, per_full);
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         hck_ff <= '0;
      end
      else
      begin
         hck_ff <= nxt_hck;
      end
   end

   // Vertical group: start pulse, shift clock, gate enable, AC pulse
   logic [12:0] vstart_at;
   logic [11:0] vclock_at, ac_at;
   logic vstart_hit, vclock_hit, ac_hit, shift_hit, line_tog, frame_tog;
   logic vst_ff, nxt_vst;
   logic vck_ff, nxt_vck;
   logic frp_ff, nxt_frp;
   logic [6:0] enb_ff, nxt_enb;

   always_comb
   begin
      vstart_at = {11'({1'b0, c.vstart_position_field} + 11'h001), 2'h0};
      vclock_at = {11'({1'b0, c.vclock_position_field} + 11'h001), 1'b0};
      ac_at = {11'({1'b0, c.ac_invert_position} + 11'h001), 1'b0};
      vstart_hit = {1'b0, hpos_ff} == vstart_at;
      vclock_hit = hpos_ff == vclock_at;
      ac_hit = hpos_ff == ac_at;
      shift_hit = c.shared_transition_bit ? ac_hit : vclock_hit;
      // Start pulse is one line wide, rising on the first line of a frame
      nxt_vst = vstart_hit ? (vline_ff == 11'h000) : vst_ff;
      nxt_vck = shift_hit ? ~vck_ff : vck_ff;
      // Skipping or adding one inversion at frame start flips the pattern
      line_tog = ~c.ac_period_mode[1];
      frame_tog = (vline_ff == 11'h000) & (~c.ac_period_mode[0] | ~frame_ff);
      nxt_frp = (ac_hit & (line_tog ^ frame_tog)) ? ~frp_ff : frp_ff;
      if (shift_hit)
      begin
         nxt_enb = {ENB_DOTS, 1'b0};
      end
      else if (enb_ff != 7'h00)
      begin
         nxt_enb = enb_ff - 7'h01;
      end
      else
      begin
         nxt_enb = enb_ff;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         vst_ff <= 1'b0;
         vck_ff <= 1'b0;
         frp_ff <= 1'b0;
         enb_ff <= '0;
      end
      else
      begin
         vst_ff <= nxt_vst;
         vck_ff <= nxt_vck;
         frp_ff <= nxt_frp;
         enb_ff <= nxt_enb;
      end
   end

   // Output stage: polarity and gating, all outputs registered
   logic samp_pos, vst_pos, vck_pos;
   logic nxt_samp_a, nxt_samp_b, nxt_dual_a, nxt_dual_b;
   logic nxt_vst_o, nxt_vck_o, nxt_enb_o, nxt_ac_o, nxt_acn_o;

   always_comb
   begin
      // Direction bits: one is forward scan
      samp_pos = out_pos(c.sampling_pol_fix, c.sampling_pol_bit,
                         c.horizontal_direction);
      vst_pos = out_pos(c.vstart_pol_fix, c.vstart_pol_bit, c.vertical_direction);
      vck_pos = out_pos(c.vclock_pol_fix, c.vclock_pol_bit, c.vertical_direction);
      nxt_samp_a = c.sampling_out_enable & (samp_raw ~^ samp_pos);
      nxt_samp_b = c.sampling_out_enable & (~samp_raw ~^ samp_pos);
      nxt_dual_a = c.dual_out_enable & (dual_a_raw ^ c.dual_pol_bit);
      nxt_dual_b = c.dual_out_enable & (dual_b_raw ^ c.dual_pol_bit);
      nxt_vst_o = c.vertical_out_enable & (vst_ff ~^ vst_pos);
      nxt_vck_o = c.vertical_out_enable & (vck_ff ~^ vck_pos);
      nxt_enb_o = c.vertical_out_enable & (enb_ff != 7'h00);
      nxt_ac_o = c.ac_out_enable & frp_ff;
      nxt_acn_o = c.ac_comp_out_enable & ~frp_ff;
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         sampling_clock_a_out <= 1'b0;
         sampling_clock_b_out <= 1'b0;
         dual_sample_clock_a_out <= 1'b0;
         dual_sample_clock_b_out <= 1'b0;
         vertical_start_pulse_out <= 1'b0;
         vertical_shift_clock_out <= 1'b0;
         gate_enable_pulse_out <= 1'b0;
         ac_drive_pulse_out <= 1'b0;
         ac_drive_pulse_n_out <= 1'b0;
         hresp_out <= 1'b0;
      end
      else
      begin
         sampling_clock_a_out <= nxt_samp_a;
         sampling_clock_b_out <= nxt_samp_b;
         dual_sample_clock_a_out <= nxt_dual_a;
         dual_sample_clock_b_out <= nxt_dual_b;
         vertical_start_pulse_out <= nxt_vst_o;
         vertical_shift_clock_out <= nxt_vck_o;
         gate_enable_pulse_out <= nxt_enb_o;
         ac_drive_pulse_out <= nxt_ac_o;
         ac_drive_pulse_n_out <= nxt_acn_o;
         hresp_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: tb_lcd_panel_drive_pulse_gen.sv
// Self-checking bench for the drive pulse generator
`default_nettype none
module tb_lcd_panel_drive_pulse_gen;
   timeunit 1ns;
   timeprecision 1ps;
   import lpg_pkg::*;
   logic clk_in, rst_n_in, hsel_in, hwrite_in, hready_in, hresp_out, pv;
   logic [15:0] haddr_in;
   logic [1:0] htrans_in;
   logic [2:0] hsize_in;
   logic [31:0] hwdata_in, hrdata_out, q;
   logic hreadyout_out, sampling_clock_a_out, sampling_clock_b_out;
   logic dual_sample_clock_a_out, dual_sample_clock_b_out, vertical_start_pulse_out;
   logic vertical_shift_clock_out, gate_enable_pulse_out;
   logic ac_drive_pulse_out, ac_drive_pulse_n_out;
   logic [7:0] hlen;
   logic [8:0] seen;
   int err_count, checked, n_cyc;
   int mode_cnt[4] = '{6, 7, 2, 1};
   assign hready_in = hreadyout_out;
   lpg_top i_dut (.*);
   lpg_panel_model i_panel (.clk_in(clk_in), .sample_in(sampling_clock_a_out),
      .high_len_out(hlen));
   always #5 clk_in = ~clk_in;
   task complete_run;
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task rdy;
      n_cyc = 0;
      do
      begin
         @(posedge clk_in);
         n_cyc++;
      end
      while (hreadyout_out !== 1'b1 && n_cyc < 100);
      if (hreadyout_out !== 1'b1)
      begin
         err_count++;
         complete_run;
      end
   endtask
   task bus(input logic w, input logic [13:0] i, input logic [31:0] d);
      @(posedge clk_in);
      htrans_in <= 2'h2;
      haddr_in <= {i, 2'h0};
      hwrite_in <= w;
      rdy;
      htrans_in <= 2'h0;
      hwdata_in <= d;
      rdy;
      q = hrdata_out;
   endtask
   function logic pick(input int s);
      return s == 0 ? vertical_shift_clock_out : s == 1 ? ac_drive_pulse_out
         : sampling_clock_a_out;
   endfunction
   // Bounded wait for the chosen output to change; pv keeps prior shift clock
   task wait_sig(input int s);
      logic v;
      n_cyc = 0;
      do
      begin
         v = pick(s);
         pv = vertical_shift_clock_out;
         @(posedge clk_in);
         n_cyc++;
      end
      while (pick(s) === v && n_cyc < 2000);
      if (pick(s) === v)
      begin
         err_count++;
         complete_run;
      end
   endtask
   task win;
      seen = '0;
      repeat (4) @(posedge clk_in);
      repeat (400)
      begin
         @(posedge clk_in);
         seen |= {sampling_clock_a_out, sampling_clock_b_out, dual_sample_clock_a_out,
            dual_sample_clock_b_out, vertical_start_pulse_out, vertical_shift_clock_out,
            gate_enable_pulse_out, ac_drive_pulse_out, ac_drive_pulse_n_out};
      end
   endtask
   task t_regs;
      bus(1'b0, IDX_PERIOD, 32'h0);
      chk(q, 32'h0b);
      bus(1'b0, IDX_POL, 32'h0);
      chk(q, 32'h30);
      bus(1'b0, IDX_LINK, 32'h0);
      chk(q, 32'h06);
      bus(1'b0, 14'h1003, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, IDX_DUAL, 32'h5a);
      bus(1'b0, IDX_DUAL, 32'h0);
      chk(q, 32'h5a);
      $display("regs done");
   endtask
   task t_period;
      bus(1'b1, IDX_LINE, 32'h60);
      bus(1'b1, IDX_FRAME, 32'h4);
      bus(1'b1, IDX_PERIOD, 32'h5);
      bus(1'b1, IDX_OE_B, 32'h7);
      bus(1'b1, IDX_OE_A, 32'h3);
      repeat (4) wait_sig(2);
      chk(hlen, 8'h06);
      $display("period done");
   endtask
   task t_pol;
      logic [2:0] k;
      for (int i = 0; i < 8; i++)
      begin
         k = i[2:0];
         bus(1'b1, IDX_LINK, {29'h0, 1'b1, k[0], 1'b0});
         bus(1'b1, IDX_POL, {31'h0, k[1]});
         bus(1'b1, IDX_FIX, {31'h0, k[2]});
         // Let the new polarity reach the pins first
         @(posedge clk_in);
         wait_sig(0);
         chk(sampling_clock_a_out, k[2] ? k[1] : k[1] == k[0]);
      end
      $display("polarity done");
   endtask
   task t_ac;
      bus(1'b1, IDX_ACPOS_LO, 32'h3);
      bus(1'b1, IDX_VCPOS_LO, 32'h9);
      repeat (2) wait_sig(1);
      wait_sig(0);
      chk(n_cyc, 12);
      chk(ac_drive_pulse_out ^ ac_drive_pulse_n_out, 1'b1);
      bus(1'b1, IDX_LINK, 32'h7);
      repeat (2) wait_sig(1);
      chk(vertical_shift_clock_out ^ pv, 1'b1);
      // Nine half-dots earlier moves the read point into the high half
      bus(1'b1, IDX_SHP, 32'h9);
      @(posedge clk_in);
      wait_sig(0);
      chk(sampling_clock_a_out, 1'b1);
      $display("ac position done");
   endtask
   task t_mode;
      int c;
      logic p;
      for (int m = 0; m < 4; m++)
      begin
         bus(1'b1, IDX_POL, 32'(m) << 4);
         repeat (1536) @(posedge clk_in);
         c = 0;
         repeat (1536)
         begin
            p = ac_drive_pulse_out;
            @(posedge clk_in);
            c += (ac_drive_pulse_out !== p);
         end
         chk(c, mode_cnt[m]);
      end
      $display("ac mode done");
   endtask
   task t_gate;
      bus(1'b1, IDX_OE_B, 32'h4);
      win;
      chk(seen & 9'h1e0, 9'h0);
      chk(seen & 9'h01c, 9'h01c);
      bus(1'b1, IDX_OE_B, 32'h3);
      win;
      chk(seen & 9'h01c, 9'h0);
      chk(seen & 9'h1e0, 9'h1e0);
      bus(1'b1, IDX_OE_A, 32'h1);
      win;
      chk(seen & 9'h001, 9'h0);
      bus(1'b1, IDX_OE_A, 32'h2);
      win;
      chk(seen & 9'h002, 9'h0);
      $display("gating done");
   endtask
   initial
   begin
      clk_in = 1'b0;
      rst_n_in = 1'b0;
      hsel_in = 1'b1;
      hsize_in = 3'h2;
      haddr_in = '0;
      htrans_in = 2'h0;
      hwrite_in = 1'b0;
      hwdata_in = '0;
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      t_regs;
      t_period;
      t_pol;
      t_ac;
      t_mode;
      t_gate;
      complete_run;
   end
endmodule
bind lpg_top lpg_properties i_props (.*);
`default_nettype wire
